// file: hw/cmp_vref_pkg.sv
package cmp_vref_pkg;

    // ==========================================================
    // bus geometry: byte address is four times the register index
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 8;

    // ==========================================================
    // register indices
    localparam logic [7:0] IDX_PORT_DATA  = 8'h05;
    localparam logic [7:0] IDX_INTR_CTL   = 8'h0B;
    localparam logic [7:0] IDX_IRQ_FLAGS  = 8'h0C;
    localparam logic [7:0] IDX_CMP_CTL    = 8'h1F;
    localparam logic [7:0] IDX_PORT_DIR   = 8'h85;
    localparam logic [7:0] IDX_IRQ_EN     = 8'h8C;
    localparam logic [7:0] IDX_REF_CTL    = 8'h9F;

    // ==========================================================
    // field positions
    localparam int GLOBAL_EN_BIT   = 7;
    localparam int PERIPH_EN_BIT   = 6;
    localparam int CHANGE_FLAG_BIT = 6;
    localparam int CHANGE_EN_BIT   = 6;
    localparam int CMP_TWO_BIT     = 7;
    localparam int CMP_ONE_BIT     = 6;
    localparam int SWITCH_BIT      = 3;
    localparam int MODE_LSB        = 0;
    localparam int REF_EN_BIT      = 7;
    localparam int REF_OE_BIT      = 6;
    localparam int REF_RANGE_BIT   = 5;
    localparam int TAP_LSB         = 0;
    localparam int PORT_W          = 5;

    // ==========================================================
    // values after reset
    localparam logic [7:0] INTR_CTL_RST  = 8'h00;
    localparam logic       FLAG_RST      = 1'b0;
    localparam logic       CHANGE_EN_RST = 1'b0;
    localparam logic [2:0] MODE_RST      = 3'h0;
    localparam logic       SWITCH_RST    = 1'b0;
    localparam logic [4:0] PORT_DIR_RST  = 5'h1F;
    localparam logic [4:0] PORT_DATA_RST = 5'h00;
    localparam logic [3:0] TAP_RST       = 4'h0;

    // ==========================================================
    // comparator modes
    localparam logic [2:0] MODE_SWITCH = 3'h1;
    localparam logic [2:0] MODE_VREF   = 3'h2;
    localparam logic [2:0] MODE_ROUTE  = 3'h6;
    localparam logic [2:0] MODE_OFF    = 3'h7;

    // ==========================================================
    // ladder level in 1/96 of supply
    localparam logic [6:0] LOW_STEP  = 7'h04;
    localparam logic [6:0] HIGH_BASE = 7'h18;
    localparam logic [6:0] HIGH_STEP = 7'h03;

    // pins that each mode makes analog inputs
    function automatic logic [4:0] analog_mask(input logic [2:0] mode);
        logic [4:0] m;
        m = 5'h0F;
        if (mode == 3'h3 || mode == MODE_ROUTE) begin
            m = 5'h07;
        end
        if (mode == MODE_OFF) begin
            m = 5'h00;
        end
        return m;
    endfunction

endpackage

// file: hw/result_sync.sv
module result_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk_in,   // system clock
    input  wire logic             rst_n_in, // synchronised reset
    input  wire logic [WIDTH-1:0] d_in,     // asynchronous results
    output logic      [WIDTH-1:0] q_out     // results on clk_in
);

    // ==========================================================
    // two flops per bit; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta;
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    meta     <= 1'b0;
                    q_out[i] <= 1'b0;
                end else begin
                    meta     <= d_in[i];
                    q_out[i] <= meta;
                end
            end
        end
    endgenerate

endmodule

// file: hw/ladder_level.sv
module ladder_level (
    input  wire logic       low_range_in, // 1 selects the low range
    input  wire logic [3:0] tap_in,       // tap 0..15
    output logic      [6:0] level_out     // level in 1/96 of supply
);

    // ==========================================================
    // low: tap/24 = 4*tap/96; high: 1/4 + tap/32 = (24 + 3*tap)/96
    logic [6:0] tap_w;

    always_comb begin
        tap_w = {3'h0, tap_in};
        if (low_range_in) begin
            level_out = 7'(tap_w * cmp_vref_pkg::LOW_STEP);
        end else begin
            level_out = 7'(cmp_vref_pkg::HIGH_BASE + 7'(tap_w * cmp_vref_pkg::HIGH_STEP));
        end
    end

endmodule

// file: hw/comparator_vref_control.sv
// Contract
// - each comparator result is high when its noninverting input exceeds its inverting input
// - mode 010 routes the ladder output to both noninverting inputs
// - result bits 7 and 6 of comparator_control read live results, writes ignored
// - mode 110 drives raw unsynchronised results onto port pins three and four
// - port direction bits still gate the pin drivers in routed mode
// - port data reads return zero for pins the mode makes analog
// - the change flag is set whenever either comparator result changes
// - software writes zero to clear the flag, one to set it
// - interrupt request needs change enable, peripheral enable and global enable
// - any comparator_control read or write ends the mismatch condition
// - a persisting mismatch keeps setting the flag until the register is accessed
// - a change coinciding with a control register read may fail to set the flag
// - comparators keep running in sleep; an enabled change wakes the device
// - mode 111 turns both comparators off
// - wake from sleep leaves comparator_control unchanged
// - reset loads mode 000 and powers the comparators down while held
// - reference bit 7 powers the ladder on, clear powers it down
// - reference output enable connects the ladder to port pin two
// - range bit set selects low range, clear selects high range
// - tap field picks tap/24 in low range, 1/4 plus tap/32 in high
// - reference bit 4 ignores writes and reads zero
// - input switch picks inverting input pins in modes 001 and 010
// - reset clears reference enable, output enable, range and tap
//
// The APB register port was chosen for this implementation.
module comparator_vref_control (
    input  wire logic        CLK_IN,                  // 100 MHz system clock
    input  wire logic        RST_N_IN,                // asynchronous reset, active low
    input  wire logic        PSEL_IN,                 // apb select
    input  wire logic        PENABLE_IN,              // apb enable
    input  wire logic        PWRITE_IN,               // apb direction
    input  wire logic [11:0] PADDR_IN,                // apb byte address
    input  wire logic [31:0] PWDATA_IN,               // apb write data
    input  wire logic [3:0]  PSTRB_IN,                // apb byte strobes
    output logic      [31:0] PRDATA_OUT,              // apb read data
    output logic             PREADY_OUT,              // apb ready
    output logic             PSLVERR_OUT,             // apb error, unmapped address
    input  wire logic        CMP_ONE_RAW_IN,          // comparator one analog result
    input  wire logic        CMP_TWO_RAW_IN,          // comparator two analog result
    input  wire logic [4:0]  PORT_PIN_IN,             // port pin levels
    output logic      [4:0]  PORT_PIN_OUT,            // port pin drive values
    output logic      [4:0]  PORT_PIN_OE_OUT,         // port pin drive enables
    output logic      [4:0]  ANALOG_PIN_OUT,          // pins set as analog inputs
    output logic             CMP_ONE_EN_OUT,          // comparator one powered
    output logic             CMP_TWO_EN_OUT,          // comparator two powered
    output logic             NONINV_VREF_SEL_OUT,     // ladder feeds noninverting inputs
    output logic             INV_SWITCH_OUT,          // alternate inverting pins
    output logic             LADDER_EN_OUT,           // ladder powered
    output logic             LADDER_PIN_DRIVE_EN_OUT, // ladder onto port pin two
    output logic             LADDER_LOW_RANGE_OUT,    // low range selected
    output logic      [3:0]  LADDER_TAP_SEL_OUT,      // tap select
    output logic      [6:0]  LADDER_LEVEL_OUT,        // level in 1/96 of supply
    output logic             IRQ_OUT,                 // comparator interrupt request
    output logic             WAKE_OUT                 // wake request from sleep
);

    // ==========================================================
    // reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ==========================================================
    // state
    logic [7:0] intr_ctl;
    logic       change_flag;
    logic       change_en;
    logic [2:0] mode;
    logic       input_switch;
    logic [4:0] port_dir;
    logic [4:0] port_latch;
    logic       ref_en;
    logic       ref_oe;
    logic       ref_low;
    logic [3:0] tap_sel;
    logic [1:0] sync_res;
    logic [1:0] seen_res;
    logic [4:0] port_q;
    logic       route_q;
    logic [6:0] next_level;
    logic [31:0] next_rdata;

    // ==========================================================
    // apb decode
    logic [7:0] idx;
    logic       setup;
    logic       mapped;
    logic       wr;
    logic       cmp_access;
    logic       mismatch;

    assign idx   = PADDR_IN[cmp_vref_pkg::IDX_LSB +: cmp_vref_pkg::IDX_W];
    assign setup = PSEL_IN & ~PENABLE_IN;

    always_comb begin
        mapped = 1'b0;
        if (PADDR_IN[11:10] == 2'h0 && PADDR_IN[1:0] == 2'h0) begin
            unique case (idx)
                cmp_vref_pkg::IDX_PORT_DATA,
                cmp_vref_pkg::IDX_INTR_CTL,
                cmp_vref_pkg::IDX_IRQ_FLAGS,
                cmp_vref_pkg::IDX_CMP_CTL,
                cmp_vref_pkg::IDX_PORT_DIR,
                cmp_vref_pkg::IDX_IRQ_EN,
                cmp_vref_pkg::IDX_REF_CTL: mapped = 1'b1;
                default:                   mapped = 1'b0;
            endcase
        end
    end

    // writes land at the access edge; only the low byte lane carries data
    assign wr = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN & mapped & PSTRB_IN[0];

    // read or write both count, taken at the setup edge so read data and latch agree
    assign cmp_access = setup & mapped & (idx == cmp_vref_pkg::IDX_CMP_CTL);

    // zero wait states: ready and data are loaded in setup, valid in access
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h0000_0000;
        end else begin
            PREADY_OUT  <= setup;
            PSLVERR_OUT <= setup & ~mapped;
            if (setup) begin
                PRDATA_OUT <= next_rdata;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (mapped && !PWRITE_IN) begin
            unique case (idx)
                cmp_vref_pkg::IDX_PORT_DATA: begin
                    next_rdata[4:0] = PORT_PIN_IN & ~cmp_vref_pkg::analog_mask(mode);
                end
                cmp_vref_pkg::IDX_INTR_CTL: begin
                    next_rdata[7:0] = intr_ctl;
                end
                cmp_vref_pkg::IDX_IRQ_FLAGS: begin
                    next_rdata[cmp_vref_pkg::CHANGE_FLAG_BIT] = change_flag;
                end
                cmp_vref_pkg::IDX_CMP_CTL: begin
                    next_rdata[cmp_vref_pkg::CMP_TWO_BIT] = sync_res[1];
                    next_rdata[cmp_vref_pkg::CMP_ONE_BIT] = sync_res[0];
                    next_rdata[cmp_vref_pkg::SWITCH_BIT]  = input_switch;
                    next_rdata[2:0]                       = mode;
                end
                cmp_vref_pkg::IDX_PORT_DIR: begin
                    next_rdata[4:0] = port_dir;
                end
                cmp_vref_pkg::IDX_IRQ_EN: begin
                    next_rdata[cmp_vref_pkg::CHANGE_EN_BIT] = change_en;
                end
                cmp_vref_pkg::IDX_REF_CTL: begin
                    next_rdata[cmp_vref_pkg::REF_EN_BIT]    = ref_en;
                    next_rdata[cmp_vref_pkg::REF_OE_BIT]    = ref_oe;
                    next_rdata[cmp_vref_pkg::REF_RANGE_BIT] = ref_low;
                    next_rdata[3:0]                         = tap_sel;
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // control registers; nothing here reacts to sleep or wake
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            mode         <= cmp_vref_pkg::MODE_RST;
            input_switch <= cmp_vref_pkg::SWITCH_RST;
        end else if (wr && idx == cmp_vref_pkg::IDX_CMP_CTL) begin
            mode         <= PWDATA_IN[2:0];
            input_switch <= PWDATA_IN[cmp_vref_pkg::SWITCH_BIT]; // results bits dropped
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ref_en  <= 1'b0;
            ref_oe  <= 1'b0;
            ref_low <= 1'b0;
            tap_sel <= cmp_vref_pkg::TAP_RST;
        end else if (wr && idx == cmp_vref_pkg::IDX_REF_CTL) begin
            ref_en  <= PWDATA_IN[cmp_vref_pkg::REF_EN_BIT];
            ref_oe  <= PWDATA_IN[cmp_vref_pkg::REF_OE_BIT];
            ref_low <= PWDATA_IN[cmp_vref_pkg::REF_RANGE_BIT];
            tap_sel <= PWDATA_IN[3:0]; // bit 4 not stored
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            intr_ctl   <= cmp_vref_pkg::INTR_CTL_RST;
            change_en  <= cmp_vref_pkg::CHANGE_EN_RST;
            port_dir   <= cmp_vref_pkg::PORT_DIR_RST;
            port_latch <= cmp_vref_pkg::PORT_DATA_RST;
        end else if (wr) begin
            if (idx == cmp_vref_pkg::IDX_INTR_CTL) begin
                intr_ctl <= PWDATA_IN[7:0];
            end
            if (idx == cmp_vref_pkg::IDX_IRQ_EN) begin
                change_en <= PWDATA_IN[cmp_vref_pkg::CHANGE_EN_BIT];
            end
            if (idx == cmp_vref_pkg::IDX_PORT_DIR) begin
                port_dir <= PWDATA_IN[4:0];
            end
            if (idx == cmp_vref_pkg::IDX_PORT_DATA) begin
                port_latch <= PWDATA_IN[4:0];
            end
        end
    end

    // ==========================================================
    // change detection; analog results arrive high when + exceeds
    result_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_in   (CLK_IN),
        .rst_n_in (rst_n),
        .d_in     ({CMP_TWO_RAW_IN, CMP_ONE_RAW_IN}),
        .q_out    (sync_res)
    );

    // a change on the setup edge misses the copy and still sets the flag a cycle later
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            seen_res <= 2'h0;
        end else if (cmp_access) begin
            seen_res <= sync_res;
        end
    end

    assign mismatch = sync_res != seen_res;

    // set beats clear, so the flag cannot be cleared while mismatch stands
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            change_flag <= cmp_vref_pkg::FLAG_RST;
        end else if (mismatch) begin
            change_flag <= 1'b1;
        end else if (wr && idx == cmp_vref_pkg::IDX_IRQ_FLAGS) begin
            change_flag <= PWDATA_IN[cmp_vref_pkg::CHANGE_FLAG_BIT];
        end
    end

    // wake ignores the global and peripheral enables
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            IRQ_OUT  <= 1'b0;
            WAKE_OUT <= 1'b0;
        end else begin
            IRQ_OUT  <= change_flag & change_en & intr_ctl[cmp_vref_pkg::PERIPH_EN_BIT]
                        & intr_ctl[cmp_vref_pkg::GLOBAL_EN_BIT];
            WAKE_OUT <= change_flag & change_en;
        end
    end

    // ==========================================================
    // analog steering and pins
    ladder_level u_level (
        .low_range_in (ref_low),
        .tap_in       (tap_sel),
        .level_out    (next_level)
    );

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            CMP_ONE_EN_OUT      <= 1'b0;
            CMP_TWO_EN_OUT      <= 1'b0;
            NONINV_VREF_SEL_OUT <= 1'b0;
            INV_SWITCH_OUT      <= 1'b0;
            ANALOG_PIN_OUT      <= 5'h0F;
        end else begin
            CMP_ONE_EN_OUT      <= mode != cmp_vref_pkg::MODE_OFF;
            CMP_TWO_EN_OUT      <= mode != cmp_vref_pkg::MODE_OFF;
            NONINV_VREF_SEL_OUT <= mode == cmp_vref_pkg::MODE_VREF;
            INV_SWITCH_OUT      <= input_switch & (mode == cmp_vref_pkg::MODE_SWITCH
                                   || mode == cmp_vref_pkg::MODE_VREF);
            ANALOG_PIN_OUT      <= cmp_vref_pkg::analog_mask(mode);
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            LADDER_EN_OUT           <= 1'b0;
            LADDER_PIN_DRIVE_EN_OUT <= 1'b0;
            LADDER_LOW_RANGE_OUT    <= 1'b0;
            LADDER_TAP_SEL_OUT      <= cmp_vref_pkg::TAP_RST;
            LADDER_LEVEL_OUT        <= 7'h00;
        end else begin
            LADDER_EN_OUT           <= ref_en;
            LADDER_PIN_DRIVE_EN_OUT <= ref_oe;
            LADDER_LOW_RANGE_OUT    <= ref_low;
            LADDER_TAP_SEL_OUT      <= tap_sel;
            LADDER_LEVEL_OUT        <= next_level;
        end
    end

    // direction bit 1 means input, so the driver is its inverse
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            PORT_PIN_OE_OUT <= 5'h00;
            port_q          <= cmp_vref_pkg::PORT_DATA_RST;
            route_q         <= 1'b0;
        end else begin
            PORT_PIN_OE_OUT <= ~port_dir;
            port_q          <= port_latch;
            route_q         <= mode == cmp_vref_pkg::MODE_ROUTE;
        end
    end

    // raw results bypass every flop here; expect glitches on the pins
    assign PORT_PIN_OUT = route_q ? {CMP_TWO_RAW_IN, CMP_ONE_RAW_IN, port_q[2:0]} : port_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!rst_n);

    flag_follows_a: assert property (mismatch |=> change_flag)
        else $error("change flag not set after mismatch");

    mismatch_holds_a: assert property (mismatch && !cmp_access |=> mismatch || $changed(sync_res))
        else $error("mismatch vanished without access");

    access_ends_a: assert property (cmp_access |=> seen_res == $past(sync_res))
        else $error("control access did not capture results");

    flag_clear_a: assert property (wr && idx == cmp_vref_pkg::IDX_IRQ_FLAGS && !mismatch
        |=> change_flag == $past(PWDATA_IN[cmp_vref_pkg::CHANGE_FLAG_BIT]))
        else $error("flag write not honoured");

    irq_gate_a: assert property (IRQ_OUT |-> $past(change_flag && change_en
        && intr_ctl[cmp_vref_pkg::PERIPH_EN_BIT] && intr_ctl[cmp_vref_pkg::GLOBAL_EN_BIT]))
        else $error("interrupt raised while gated");

    result_read_a: assert property (cmp_access && !PWRITE_IN
        |=> PRDATA_OUT[7:6] == $past(sync_res) && PREADY_OUT)
        else $error("result bits read wrong");

    route_pins_a: assert property (route_q |-> PORT_PIN_OUT[3] == CMP_ONE_RAW_IN
        && PORT_PIN_OUT[4] == CMP_TWO_RAW_IN)
        else $error("routed pins not raw results");

    pin_enable_a: assert property (rst_n |=> PORT_PIN_OE_OUT == ~$past(port_dir))
        else $error("pin enable not from direction");

    off_mode_a: assert property (mode == cmp_vref_pkg::MODE_OFF |=> !CMP_ONE_EN_OUT && !CMP_TWO_EN_OUT)
        else $error("comparators not off in mode 111");

    analog_read_a: assert property (setup && mapped && !PWRITE_IN && idx == cmp_vref_pkg::IDX_PORT_DATA
        |=> (PRDATA_OUT[4:0] & $past(cmp_vref_pkg::analog_mask(mode))) == 5'h00)
        else $error("analog pin read nonzero");

    ladder_level_a: assert property (rst_n |=> LADDER_LEVEL_OUT == ($past(ref_low)
        ? 7'($past(tap_sel)) * 7'h04 : 7'h18 + 7'($past(tap_sel)) * 7'h03))
        else $error("ladder level wrong");

    unused_bit_a: assert property (setup && idx == cmp_vref_pkg::IDX_REF_CTL |=> !PRDATA_OUT[4])
        else $error("reference bit 4 reads one");

endmodule

// file: verification/analog_side.sv
module analog_side (
    input  wire logic [6:0] pos_in,      // external noninverting level
    input  wire logic [6:0] neg_one_in,  // inverting level, one
    input  wire logic [6:0] neg_two_in,  // inverting level, two
    input  wire logic [6:0] ladder_in,   // ladder level
    input  wire logic       vref_sel_in, // ladder on noninverting
    input  wire logic [4:0] drive_in,    // pin drive values
    input  wire logic [4:0] oe_in,       // pin drive enables
    output logic            one_out,     // result one
    output logic            two_out,     // result two
    output logic      [4:0] pin_out      // pin levels
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // comparators and pins
    logic [6:0] pos;
    assign pos = vref_sel_in ? ladder_in : pos_in;
    assign one_out = pos > neg_one_in;
    assign two_out = pos > neg_two_in;
    // released pins sit high on pull-ups
    assign pin_out = (drive_in & oe_in) | ~oe_in;
endmodule

// file: verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // stimulus and checks
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready, pslverr, one, two, en1, vsel, irq, wake, err;
    logic        en2, isw, ren, roe, rlow;
    logic [3:0]  rtap;
    logic [6:0]  pos = 7'h00;
    logic [6:0]  neg1 = 7'h50;
    logic [6:0]  neg2 = 7'h50;
    logic [6:0]  lvl;
    logic [4:0]  pin, pdrv, poe, apin;
    logic [7:0]  rd;
    int          miscompares = 0;
    int          tests_run = 0;

    always #5 clk = ~clk;

    analog_side far (.pos_in(pos), .neg_one_in(neg1), .neg_two_in(neg2), .ladder_in(lvl),
        .vref_sel_in(vsel), .drive_in(pdrv), .oe_in(poe), .one_out(one), .two_out(two), .pin_out(pin));

    comparator_vref_control dut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hF), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CMP_ONE_RAW_IN(one), .CMP_TWO_RAW_IN(two),
        .PORT_PIN_IN(pin), .PORT_PIN_OUT(pdrv), .PORT_PIN_OE_OUT(poe), .ANALOG_PIN_OUT(apin),
        .CMP_ONE_EN_OUT(en1), .CMP_TWO_EN_OUT(en2), .NONINV_VREF_SEL_OUT(vsel), .INV_SWITCH_OUT(isw),
        .LADDER_EN_OUT(ren), .LADDER_PIN_DRIVE_EN_OUT(roe), .LADDER_LOW_RANGE_OUT(rlow),
        .LADDER_TAP_SEL_OUT(rtap),
        .LADDER_LEVEL_OUT(lvl), .IRQ_OUT(irq), .WAKE_OUT(wake));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        chk({1'b0, apin, en2, en1}, 8'h3C);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(cmp_vref_pkg::IDX_CMP_CTL, 8'h00);
        rdc(cmp_vref_pkg::IDX_REF_CTL, 8'h00);
        $display("test reset done");
        wr(cmp_vref_pkg::IDX_CMP_CTL, 8'hFF);
        rdc(cmp_vref_pkg::IDX_CMP_CTL, 8'h0F);
        chk({1'b0, apin, en2, en1}, 8'h00);
        chk({7'h00, isw}, 8'h00);
        wr(cmp_vref_pkg::IDX_REF_CTL, 8'hFF);
        rdc(cmp_vref_pkg::IDX_REF_CTL, 8'hEF);
        chk({1'b0, lvl}, 8'h3C);
        chk({ren, roe, rlow, 1'b0, rtap}, 8'hEF);
        wr(cmp_vref_pkg::IDX_REF_CTL, 8'h8F);
        rdc(cmp_vref_pkg::IDX_REF_CTL, 8'h8F);
        chk({1'b0, lvl}, 8'h45);
        chk({ren, roe, rlow, 1'b0, rtap}, 8'h8F);
        $display("test registers done");
        wr(cmp_vref_pkg::IDX_IRQ_EN, 8'h40);
        wr(cmp_vref_pkg::IDX_INTR_CTL, 8'hC0);
        wr(cmp_vref_pkg::IDX_CMP_CTL, 8'h0A);
        neg1 <= 7'h10;
        repeat (6) @(posedge clk);
        chk({7'h00, vsel}, 8'h01);
        chk({5'h00, isw, en2, en1}, 8'h07);
        chk({6'h00, wake, irq}, 8'h03);
        rdc(cmp_vref_pkg::IDX_IRQ_FLAGS, 8'h40);
        wr(cmp_vref_pkg::IDX_IRQ_FLAGS, 8'h00);
        rdc(cmp_vref_pkg::IDX_IRQ_FLAGS, 8'h40);
        rdc(cmp_vref_pkg::IDX_CMP_CTL, 8'h4A);
        wr(cmp_vref_pkg::IDX_IRQ_FLAGS, 8'h00);
        rdc(cmp_vref_pkg::IDX_IRQ_FLAGS, 8'h00);
        wr(cmp_vref_pkg::IDX_IRQ_FLAGS, 8'h40);
        wr(cmp_vref_pkg::IDX_INTR_CTL, 8'h40);
        rdc(cmp_vref_pkg::IDX_IRQ_FLAGS, 8'h40);
        chk({6'h00, wake, irq}, 8'h02);
        $display("test change flag done");
        wr(cmp_vref_pkg::IDX_CMP_CTL, 8'h06);
        pos <= 7'h20;
        wr(cmp_vref_pkg::IDX_PORT_DIR, 8'h17);
        rdc(cmp_vref_pkg::IDX_PORT_DATA, 8'h18);
        chk({3'h0, poe}, 8'h08);
        chk({2'h0, isw, apin}, 8'h07);
        chk({6'h00, pdrv[4:3]}, 8'h01);
        apb(1'b0, 8'h40, 8'h00);
        chk({7'h00, err}, 8'h01);
        $display("test port routing done");
        conclude();
    end

    initial begin
        repeat (4000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule
